// ### include/ccc_pkg.sv
`default_nettype none
package ccc_pkg;
   localparam int CLK_KHZ = 25000;
   localparam int POWERUP_MS = 30;
   localparam int CONV_MS = 30;
   localparam int RATE_364_MS = 364;
   localparam int RATE_1000_MS = 1000;
   localparam int RATE_2500_MS = 2500;
   localparam int POWERUP_CYC = POWERUP_MS * CLK_KHZ;
   localparam int CONV_CYC = CONV_MS * CLK_KHZ;
   localparam int RATE_364_CYC = RATE_364_MS * CLK_KHZ;
   localparam int RATE_1000_CYC = RATE_1000_MS * CLK_KHZ;
   localparam int RATE_2500_CYC = RATE_2500_MS * CLK_KHZ;

   localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
   localparam logic [7:0] CMD_CONFIG = 8'h03;
   localparam logic [7:0] CMD_RATE = 8'h04;
   localparam logic [7:0] CMD_CHAN_EN = 8'h05;
   localparam logic [7:0] CMD_FILTER = 8'h06;
   localparam logic [7:0] CMD_DIODE_FAULT = 8'h07;
   localparam logic [7:0] CMD_TRIGGER = 8'h0F;

   localparam logic [7:0] RST_COMMON_STATUS = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h02;
   localparam logic [7:0] RST_CHAN_EN = 8'h1F;
   localparam logic [7:0] RST_FILTER = 8'h0F;

   localparam int BIT_BUSY = 7;
   localparam int BIT_PENDING = 6;
   localparam int BIT_STANDBY = 6;

   localparam logic [1:0] RATE_CONT = 2'h0;
   localparam logic [1:0] RATE_364 = 2'h1;
   localparam logic [1:0] RATE_1000 = 2'h2;

   localparam logic [1:0] CH_NONE = 2'h3;
   localparam logic [7:0] FAULT_UNSIGNED = 8'h00;
   localparam logic [7:0] FAULT_SIGNED = 8'h80;

   typedef enum logic [2:0]
   {
      ST_STANDBY = 3'b001,
      ST_CONVERT = 3'b010,
      ST_FILL = 3'b100
   } ccc_state_e;

   typedef struct packed
   {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccc_cmd_s;

   typedef struct packed
   {
      logic [7:0] unsigned_val;
      logic [7:0] signed_val;
   } ccc_result_s;
endpackage : ccc_pkg
`default_nettype wire

// ### logic/ccc_channel_control.sv
`default_nettype none
// Summary of operation
// - Channels with cleared enable are skipped; only enabled channels convert.
// - Continuous rate shortens with fewer channels; other rates pad standby time.
// - Channel enable at 0x05: remote2 bit 2, remote1 bit 1, local bit 0.
// - Filter register at 0x06: remote2 bits 3-2, remote1 bits 1-0.
// - A write to 0x0F in standby, after power-up and with no sequence running, starts one sequence of enabled channels.
// - Trigger register is write-only; written data is neither used nor kept.
// - Common status 0x02 bit 7 is busy while converting.
// - Common status bit 6 reads one during the 30 ms power-up.
// - Common status bits 3-0 are the OR of status registers 4 to 1.
// - Reserved bits of these registers read zero.
// - Diode fault register 0x07 is read-only with open/short bits per remote.
// - Input at ground or negative terminal is short; at supply or floating is open.
// - Faulted remote reads 0 unsigned and -128 signed.
// - Configuration bit 6 selects standby; trigger works only in standby.
// - Rate field picks continuous, 0.364 s, 1 s or 2.5 s sequence interval.
module ccc_channel_control #(
   parameter int POWERUP_CYCLES = ccc_pkg::POWERUP_CYC,
   parameter int CONV_CYCLES = ccc_pkg::CONV_CYC,
   parameter int RATE_364_CYCLES = ccc_pkg::RATE_364_CYC,
   parameter int RATE_1000_CYCLES = ccc_pkg::RATE_1000_CYC,
   parameter int RATE_2500_CYCLES = ccc_pkg::RATE_2500_CYC
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic link_clk_in,
   input wire logic cmd_valid_in,
   input wire ccc_pkg::ccc_cmd_s cmd_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   input wire logic [1:0] diode_high_in,
   input wire logic [1:0] diode_low_in,
   input wire logic [2:0][2:0] crit_status_in,
   input wire ccc_pkg::ccc_result_s [1:0] remote_raw_in,
   output ccc_pkg::ccc_result_s [1:0] remote_result_out,
   output logic [2:0] conv_chan_out,
   output logic busy_out,
   output logic [1:0] remote1_filter_sel_out,
   output logic [1:0] remote2_filter_sel_out
);
   import ccc_pkg::*;

   typedef struct packed
   {
      ccc_state_e st;
      logic [1:0] chan;
      logic oneshot;
      logic [31:0] conv_cnt;
      logic [31:0] seq_cnt;
      logic [31:0] pwr_cnt;
      logic pending;
      logic standby_ctl;
      logic [1:0] sequence_interval_sel;
      logic [2:0] chan_en;
      logic [3:0] filt;
      logic [1:0] req_s;
      logic req_seen;
      logic ack_tgl;
      logic [7:0] rdata;
      logic [1:0] high_m;
      logic [1:0] high_s;
      logic [1:0] low_m;
      logic [1:0] low_s;
      logic [3:0] fault;
      logic [3:0] summary;
      ccc_result_s [1:0] result;
      logic [2:0] conv_chan;
      logic busy;
   } ccc_core_s;

   typedef struct packed
   {
      logic [1:0] rstn_s;
      ccc_cmd_s cmd;
      logic req_tgl;
      logic ack_m;
      logic ack_s;
      logic ack_seen;
      logic ready;
      logic rsp_valid;
      logic [7:0] rsp_data;
   } ccc_link_s;

   ccc_core_s q;
   ccc_core_s d;
   ccc_link_s lq;
   ccc_link_s ld;

   function automatic logic [1:0] next_chan(input logic [2:0] en, input logic [1:0] from);
      logic [1:0] r;
      r = CH_NONE;
      for (int i = 2; i >= 0; i--)
      begin
         if (en[i] && 2'(i) >= from)
         begin
            r = 2'(i);
         end
      end
      return r;
   endfunction : next_chan

   function automatic logic [31:0] interval(input logic [1:0] sel);
      case (sel)
         RATE_CONT: interval = 32'h1;
         RATE_364: interval = 32'(RATE_364_CYCLES);
         RATE_1000: interval = 32'(RATE_1000_CYCLES);
         default: interval = 32'(RATE_2500_CYCLES);
      endcase
   endfunction : interval

   always_comb
   begin
      logic edge_seen;
      logic trig;
      logic start_seq;
      logic [1:0] nc;
      d = q;
      edge_seen = 1'b0;
      trig = 1'b0;
      start_seq = 1'b0;
      nc = CH_NONE;

      d.req_s = {q.req_s[0], lq.req_tgl};
      d.high_m = diode_high_in;
      d.high_s = q.high_m;
      d.low_m = diode_low_in;
      d.low_s = q.low_m;
      // Low side means short, high or floating means open
      d.fault = {q.high_s[1], q.low_s[1], q.high_s[0], q.low_s[0]};
      d.summary = {|crit_status_in[2], |crit_status_in[1], |crit_status_in[0], |q.fault};
      for (int i = 0; i < 2; i++)
      begin
         if (q.fault[2 * i] || q.fault[2 * i + 1])
         begin
            d.result[i].unsigned_val = FAULT_UNSIGNED;
            d.result[i].signed_val = FAULT_SIGNED;
         end
         else
         begin
            d.result[i] = remote_raw_in[i];
         end
      end

      if (q.pending)
      begin
         if (q.pwr_cnt == 32'(POWERUP_CYCLES - 1))
         begin
            d.pending = 1'b0;
         end
         d.pwr_cnt = q.pwr_cnt + 32'h1;
      end
      if (q.seq_cnt != 32'hFFFFFFFF)
      begin
         d.seq_cnt = q.seq_cnt + 32'h1;
      end

      edge_seen = q.req_s[1] ^ q.req_seen;
      if (edge_seen)
      begin
         d.req_seen = q.req_s[1];
         d.ack_tgl = ~q.ack_tgl;
         d.rdata = 8'h00;
         if (lq.cmd.write)
         begin
            case (lq.cmd.addr)
               CMD_CONFIG: d.standby_ctl = lq.cmd.wdata[BIT_STANDBY];
               CMD_RATE: d.sequence_interval_sel = lq.cmd.wdata[1:0];
               CMD_CHAN_EN: d.chan_en = lq.cmd.wdata[2:0];
               CMD_FILTER: d.filt = lq.cmd.wdata[3:0];
               CMD_TRIGGER: trig = 1'b1;
               default: d.rdata = 8'h00;
            endcase
         end
         else
         begin
            case (lq.cmd.addr)
               CMD_COMMON_STATUS: d.rdata = {q.busy, q.pending, 2'h0, q.summary};
               CMD_CONFIG: d.rdata = {1'b0, q.standby_ctl, 6'h00};
               CMD_RATE: d.rdata = {6'h00, q.sequence_interval_sel};
               CMD_CHAN_EN: d.rdata = {5'h00, q.chan_en};
               CMD_FILTER: d.rdata = {4'h0, q.filt};
               CMD_DIODE_FAULT: d.rdata = {4'h0, q.fault};
               default: d.rdata = 8'h00;
            endcase
         end
      end

      case (q.st)
         ST_STANDBY:
         begin
            // Triggers outside standby or during init fall through unused
            if (!q.pending && (!q.standby_ctl || trig))
            begin
               start_seq = 1'b1;
            end
         end
         ST_CONVERT:
         begin
            d.conv_cnt = q.conv_cnt + 32'h1;
            if (q.conv_cnt >= 32'(CONV_CYCLES - 1))
            begin
               // Enables sampled per channel so a mid-sequence clear still skips
               // Remote 2 is the last channel; a 2-bit increment from it gives 3, which is CH_NONE
               nc = (q.chan == 2'h2) ? CH_NONE : next_chan(q.chan_en, q.chan + 2'h1);
               d.conv_cnt = 32'h0;
               if (nc != CH_NONE)
               begin
                  d.chan = nc;
               end
               else if (q.oneshot || q.standby_ctl)
               begin
                  d.st = ST_STANDBY;
                  d.oneshot = 1'b0;
               end
               else if (q.sequence_interval_sel == RATE_CONT)
               begin
                  start_seq = 1'b1;
               end
               else
               begin
                  d.st = ST_FILL;
               end
            end
         end
         ST_FILL:
         begin
            if (q.standby_ctl)
            begin
               d.st = ST_STANDBY;
            end
            else if (q.seq_cnt >= interval(q.sequence_interval_sel) - 32'h1)
            begin
               start_seq = 1'b1;
            end
         end
         default: d.st = ST_STANDBY;
      endcase

      if (start_seq)
      begin
         d.seq_cnt = 32'h0;
         d.conv_cnt = 32'h0;
         d.oneshot = q.standby_ctl;
         nc = next_chan(q.chan_en, 2'h0);
         if (nc != CH_NONE)
         begin
            d.st = ST_CONVERT;
            d.chan = nc;
         end
         else
         begin
            d.st = q.standby_ctl ? ST_STANDBY : ST_FILL;
            d.oneshot = 1'b0;
         end
      end
      d.conv_chan = (d.st == ST_CONVERT) ? 3'(3'h1 << d.chan) : 3'h0;
      d.busy = (d.st == ST_CONVERT);
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         q <= '0;
         q.st <= ST_STANDBY;
         q.pending <= 1'b1;
         q.standby_ctl <= RST_CONFIG[BIT_STANDBY];
         q.sequence_interval_sel <= RST_RATE[1:0];
         q.chan_en <= RST_CHAN_EN[2:0];
         q.filt <= RST_FILTER[3:0];
         q.summary <= RST_COMMON_STATUS[3:0];
      end
      else
      begin
         q <= d;
      end
   end

   // Link side: one request in flight, held stable until the core acknowledges
   always_comb
   begin
      ld = lq;
      ld.rstn_s = {lq.rstn_s[0], resetn_in};
      ld.ack_m = q.ack_tgl;
      ld.ack_s = lq.ack_m;
      ld.rsp_valid = 1'b0;
      if (cmd_valid_in && lq.ready)
      begin
         ld.cmd = cmd_in;
         ld.req_tgl = ~lq.req_tgl;
         ld.ready = 1'b0;
      end
      if (lq.ack_s != lq.ack_seen)
      begin
         ld.ack_seen = lq.ack_s;
         ld.rsp_valid = 1'b1;
         ld.rsp_data = q.rdata;
         ld.ready = 1'b1;
      end
      if (!lq.rstn_s[1])
      begin
         ld.cmd = '0;
         ld.req_tgl = 1'b0;
         ld.ack_seen = 1'b0;
         ld.ready = 1'b1;
         ld.rsp_valid = 1'b0;
         ld.rsp_data = 8'h00;
      end
   end

   always_ff @(posedge link_clk_in)
   begin
      lq <= ld;
   end

   assign cmd_ready_out = lq.ready;
   assign rsp_valid_out = lq.rsp_valid;
   assign rsp_data_out = lq.rsp_data;
   assign remote_result_out = q.result;
   assign conv_chan_out = q.conv_chan;
   assign busy_out = q.busy;
   assign remote1_filter_sel_out = q.filt[1:0];
   assign remote2_filter_sel_out = q.filt[3:2];
endmodule : ccc_channel_control
`default_nettype wire

// ### testbench/ccc_chk.sv
`default_nettype none
module ccc_chk (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic link_clk_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_ready_out,
   input wire logic rsp_valid_out,
   input wire logic [1:0] diode_high_in,
   input wire logic [1:0] diode_low_in,
   input wire ccc_pkg::ccc_result_s [1:0] remote_raw_in,
   input wire ccc_pkg::ccc_result_s [1:0] remote_result_out,
   input wire logic [2:0] conv_chan_out,
   input wire logic busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import ccc_pkg::*;
   localparam logic [15:0] FLT = {FAULT_UNSIGNED, FAULT_SIGNED};
   // Five cycles cover the two-stage pin synchroniser, the fault register and the result register
   a_chan_onehot: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      $onehot0(conv_chan_out)) else $error("two channels at once");
   a_chan_busy: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      conv_chan_out != 3'h0 |-> busy_out) else $error("converting while not busy");
   a_open_r1: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      diode_high_in[0] [*5] |-> remote_result_out[0] == FLT)
      else $error("open remote 1 not forced");
   a_short_r2: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      diode_low_in[1] [*5] |-> remote_result_out[1] == FLT)
      else $error("short remote 2 not forced");
   a_clean_r1: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      (!diode_high_in[0] && !diode_low_in[0]) [*5]
      |-> remote_result_out[0] == $past(remote_raw_in[0])) else $error("remote 1 altered");
   a_ready_drop: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
      cmd_valid_in && cmd_ready_out |=> !cmd_ready_out) else $error("ready held after take");
   a_rsp_bound: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
      cmd_valid_in && cmd_ready_out |-> ##[2:10] rsp_valid_out) else $error("no response");
   a_rsp_pulse: assert property (@(posedge link_clk_in) disable iff (!resetn_in)
      rsp_valid_out |=> !rsp_valid_out) else $error("response too long");
endmodule : ccc_chk
bind ccc_channel_control ccc_chk u_chk (.ref_clk_in, .resetn_in, .link_clk_in, .cmd_valid_in,
   .cmd_ready_out, .rsp_valid_out, .diode_high_in, .diode_low_in, .remote_raw_in,
   .remote_result_out, .conv_chan_out, .busy_out);
`default_nettype wire

// ### testbench/ccc_host.sv
`default_nettype none
module ccc_host (
   input wire logic link_clk_in,
   input wire logic cmd_ready_in,
   input wire logic rsp_valid_in,
   input wire logic [7:0] rsp_data_in,
   output logic cmd_valid_out,
   output ccc_pkg::ccc_cmd_s cmd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import ccc_pkg::*;
   initial cmd_valid_out = 1'b0;
   initial cmd_out = '0;
   // One command in flight; callers never ask for filter code 10
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge link_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_out <= '{write: w, addr: a, wdata: d};
      do @(posedge link_clk_in); while (cmd_ready_in !== 1'b1);
      cmd_valid_out <= 1'b0;
      // Released lines must not keep showing the old command
      cmd_out <= ~cmd_out;
      do @(posedge link_clk_in); while (rsp_valid_in !== 1'b1);
      q = rsp_data_in;
   endtask : xfer
endmodule : ccc_host
`default_nettype wire

// ### testbench/channel_conversion_control_test.sv
`default_nettype none
module channel_conversion_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import ccc_pkg::*;
   localparam int CV = 40;
   logic ref_clk_in = 1'b0;
   logic link_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cmd_valid_in;
   ccc_cmd_s cmd_in;
   logic cmd_ready_out;
   logic rsp_valid_out;
   logic [7:0] rsp_data_out;
   logic [1:0] diode_high_in = 2'h0;
   logic [1:0] diode_low_in = 2'h0;
   logic [2:0][2:0] crit_status_in = '0;
   ccc_result_s [1:0] remote_raw_in = 32'h19A5_2A55;
   ccc_result_s [1:0] remote_result_out;
   logic [2:0] conv_chan_out;
   logic busy_out;
   logic [1:0] f1, f2;
   logic [2:0] seen;
   int last_cyc [3] = '{-1, -1, -1};
   int mark = 0, n0 = 0;
   int ncyc = 0, cyc = 0, n_mismatch = 0, compares = 0;
   logic [7:0] q;
   logic [1:0] fc [3] = '{2'h0, 2'h1, 2'h3};
   logic [2:0] ens [6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h0, 3'h7};
   ccc_channel_control #(.POWERUP_CYCLES(200), .CONV_CYCLES(CV)) u_dut (.ref_clk_in,
      .resetn_in, .link_clk_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .rsp_valid_out,
      .rsp_data_out, .diode_high_in, .diode_low_in, .crit_status_in, .remote_raw_in,
      .remote_result_out, .conv_chan_out, .busy_out, .remote1_filter_sel_out(f1),
      .remote2_filter_sel_out(f2));
   ccc_host u_host (.link_clk_in, .cmd_ready_in(cmd_ready_out), .rsp_valid_in(rsp_valid_out),
      .rsp_data_in(rsp_data_out), .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in));
   initial forever #20 ref_clk_in = ~ref_clk_in;
   // Offset keeps link edges off the core edges
   initial #7 forever #62.5 link_clk_in = ~link_clk_in;
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      ncyc <= ncyc + int'(conv_chan_out != 3'h0);
      for (int k = 0; k < 3; k++)
      begin
         if (conv_chan_out[k])
         begin
            last_cyc[k] <= cyc;
         end
      end
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
      u_host.xfer(1'b0, a, 8'h00, q);
      chk({24'h0, q}, {24'h0, e}, nm);
   endtask : rc
   task automatic summarize();
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (3) @(posedge link_clk_in);
      @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      repeat (3) @(posedge link_clk_in);
      rc(CMD_COMMON_STATUS, 8'h40, "status at power-up");
      rc(CMD_CHAN_EN, 8'h07, "enable reset");
      rc(CMD_FILTER, RST_FILTER, "filter reset");
      rc(CMD_TRIGGER, 8'h00, "trigger readback");
      rc(CMD_DIODE_FAULT, 8'h00, "fault idle");
      repeat (250) @(posedge ref_clk_in);
      wr(CMD_CONFIG, 8'h40);
      repeat (300) @(posedge ref_clk_in);
      rc(CMD_COMMON_STATUS, 8'h00, "status ready");
      foreach (fc[i])
      begin
         wr(CMD_FILTER, {4'hF, fc[i], fc[2 - i]});
         rc(CMD_FILTER, {4'h0, fc[i], fc[2 - i]}, "filter field");
         chk({28'h0, f2, f1}, {28'h0, fc[i], fc[2 - i]}, "filter outputs");
      end
      foreach (ens[i])
      begin
         wr(CMD_CHAN_EN, {5'h1F, ens[i]});
         mark = cyc;
         n0 = ncyc;
         wr(CMD_TRIGGER, 8'h5A ^ {5'h0, ens[i]});
         repeat (300) @(posedge ref_clk_in);
         seen = {last_cyc[2] >= mark, last_cyc[1] >= mark, last_cyc[0] >= mark};
         chk({29'h0, seen}, {29'h0, ens[i]}, "channels converted");
         chk(32'(ncyc - n0), 32'($countones(ens[i]) * CV), "conversion cycles");
      end
      n0 = ncyc;
      wr(CMD_TRIGGER, 8'h00);
      wr(CMD_TRIGGER, 8'hFF);
      rc(CMD_COMMON_STATUS, 8'h80, "busy flag");
      repeat (300) @(posedge ref_clk_in);
      chk(32'(ncyc - n0), 32'(3 * CV), "single sequence");
      @(posedge ref_clk_in);
      diode_high_in <= 2'h1;
      diode_low_in <= 2'h2;
      repeat (6) @(posedge ref_clk_in);
      chk(remote_result_out, 32'h0080_0080, "faulted results");
      rc(CMD_DIODE_FAULT, 8'h06, "fault bits");
      rc(CMD_COMMON_STATUS, 8'h01, "fault summary");
      wr(CMD_DIODE_FAULT, 8'h00);
      @(posedge ref_clk_in);
      diode_high_in <= 2'h2;
      diode_low_in <= 2'h1;
      repeat (6) @(posedge ref_clk_in);
      rc(CMD_DIODE_FAULT, 8'h09, "fault swap");
      @(posedge ref_clk_in);
      diode_high_in <= 2'h0;
      diode_low_in <= 2'h0;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge ref_clk_in);
         crit_status_in <= 9'(1 << (4 * i));
         rc(CMD_COMMON_STATUS, 8'(2 << i), "status summary");
      end
      chk(remote_result_out, remote_raw_in, "clean results");
      summarize();
   end
endmodule : channel_conversion_control_test
`default_nettype wire
